// File: core/fps_host_ctrl.sv
// Purpose: host controller that reads partition status and sets partition layout
// Assumes: software on Avalon-MM; flash on its asynchronous pins
// Notes:   commands arriving while busy are refused and flagged
//
// Functional notes
// - Poll bit 7 for completion; bits 6 to 1 invalid while busy.
// - Mask status bits 15 to 8 and bit 0.
// - If not accepted, issue E8H again and recheck.
// - Mask extended status bits 15 to 8 and 6 to 0.
// - Mask partition register bits 15 to 11 and 7 to 0.
// - Set layout by 60H then 04H, code on address 15 to 0.
// - Status read: 70H to partition address, then read same partition.
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fps_host_ctrl
  #(
    parameter bit TOP_VARIANT = 1'b0
  )
  (
    input  wire logic          core_clk,
    input  wire logic          reset_n,
    input  wire logic          clk_en,
    input  wire logic [4:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    output fps_pkg::fps_pins_t flash_pins,
    output logic               flash_rst_n,
    input  wire logic [15:0]   flash_dq_in
  );

  typedef enum logic [2:0] {
    S_RECOV  = 3'b000,
    S_IDLE   = 3'b001,
    S_FIRST  = 3'b011,
    S_FWAIT  = 3'b010,
    S_SECOND = 3'b110,
    S_SWAIT  = 3'b111,
    S_EVAL   = 3'b101
  } fps_state_t;

  localparam logic [2:0] LAYOUT_DEF =
    TOP_VARIANT ? fps_pkg::LAYOUT_TOP_DEF : fps_pkg::LAYOUT_BOT_DEF;

  fps_state_t       state;
  fps_state_t       next_state;
  fps_pkg::fps_op_t op;
  fps_pkg::fps_op_t next_op;
  logic [7:0]       rec_cnt;
  logic [7:0]       next_rec_cnt;
  logic [3:0]       tries;
  logic [3:0]       next_tries;
  logic             cyc_start;
  logic             next_cyc_start;
  logic             cyc_read;
  logic             next_cyc_read;
  logic [21:0]      cyc_addr;
  logic [21:0]      next_cyc_addr;
  logic [15:0]      cyc_wdata;
  logic [15:0]      next_cyc_wdata;
  logic             cyc_done;
  logic [15:0]      cyc_rdata;
  logic [7:0]       stat_byte;
  logic [7:0]       next_stat_byte;
  logic [7:0]       errs;
  logic [7:0]       next_errs;
  logic             buf_avail;
  logic             next_buf_avail;
  logic             gave_up;
  logic             next_gave_up;
  logic [2:0]       layout_rd;
  logic [2:0]       next_layout_rd;
  logic             next_flash_rst_n;
  logic [21:0]      part_addr;
  logic [21:0]      next_part_addr;
  logic [2:0]       layout_req;
  logic [2:0]       next_layout_req;
  logic             rejected;
  logic             next_rejected;
  logic             next_waitrequest;
  logic [31:0]      next_readdata;
  logic             wr_ok;
  logic             ctrl_wr;
  logic             op_valid;
  logic             busy;
  logic             go;
  logic             is_stat;
  logic             ready;
  logic [21:0]      cfg_addr;

  // ********************
  // register slave
  // ********************
  assign wr_ok    = avs_write && !avs_waitrequest;
  assign ctrl_wr  = wr_ok && avs_address == fps_pkg::REG_CTRL && avs_byteenable[0];
  assign op_valid = avs_writedata[2:0] != 3'h0 && avs_writedata[2:0] != 3'h7;
  assign busy     = state != S_IDLE;
  assign go       = ctrl_wr && op_valid && !busy;

  always_comb
  begin
    logic [23:0] addr_tmp;
    addr_tmp         = {2'h0, part_addr};
    next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
    next_readdata    = avs_readdata;
    next_part_addr   = part_addr;
    next_layout_req  = layout_req;
    // a refusal in the same cycle as its clear survives
    next_rejected    = ctrl_wr && op_valid && busy;
    if (!(wr_ok && avs_address == fps_pkg::REG_STATUS && avs_byteenable[2]
          && avs_writedata[fps_pkg::REJECT_BIT]))
    begin
      next_rejected = next_rejected || rejected;
    end
    // address and layout are frozen while a sequence uses them
    if (wr_ok && !busy && avs_address == fps_pkg::REG_ADDR)
    begin
      for (int b = 0; b < 3; b++)
      begin
        if (avs_byteenable[b])
        begin
          addr_tmp[b*8 +: 8] = avs_writedata[b*8 +: 8];
        end
      end
      next_part_addr = addr_tmp[21:0];
    end
    if (wr_ok && !busy && avs_address == fps_pkg::REG_LAYOUT && avs_byteenable[0])
    begin
      next_layout_req = avs_writedata[2:0];
    end
    if (avs_read && avs_waitrequest)
    begin
      unique case (avs_address)
        fps_pkg::REG_CTRL:
          next_readdata = {15'h0000, busy, 13'h0000, op};
        fps_pkg::REG_ADDR:
          next_readdata = {10'h000, part_addr};
        fps_pkg::REG_LAYOUT:
          next_readdata = {25'h0000000, fps_pkg::fps_part_count(layout_req), 1'b0, layout_req};
        fps_pkg::REG_STATUS:
          next_readdata = {12'h000, stat_byte[5] && stat_byte[4],
                           gave_up, rejected, busy, 1'b0,
                           fps_pkg::fps_part_count(layout_rd), layout_rd,
                           buf_avail, stat_byte};
        fps_pkg::REG_ERRORS:
          next_readdata = {24'h000000, errs};
        default:
          next_readdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      part_addr       <= 22'h000000;
      layout_req      <= LAYOUT_DEF;
      rejected        <= 1'b0;
    end
    else if (clk_en)
    begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata    <= next_readdata;
      part_addr       <= next_part_addr;
      layout_req      <= next_layout_req;
      rejected        <= next_rejected;
    end
  end

  // ********************
  // command sequencer
  // ********************
  assign is_stat  = op == fps_pkg::OP_STATUS || op == fps_pkg::OP_POLL;
  assign ready    = cyc_rdata[fps_pkg::READY_BIT];
  assign cfg_addr = {part_addr[21:16], 5'h00, layout_req, 8'h00};

  always_comb
  begin
    next_state       = state;
    next_op          = op;
    next_rec_cnt     = rec_cnt;
    next_tries       = tries;
    next_cyc_start   = 1'b0;
    next_cyc_read    = cyc_read;
    next_cyc_addr    = cyc_addr;
    next_cyc_wdata   = cyc_wdata;
    next_stat_byte   = stat_byte;
    next_errs        = errs;
    next_buf_avail   = buf_avail;
    next_gave_up     = gave_up;
    next_layout_rd   = layout_rd;
    next_flash_rst_n = 1'b1;
    unique case (state)
      S_RECOV:
        // the flash needs recovery time after its reset pin rises
        if (rec_cnt == fps_pkg::REC_CYC)
        begin
          next_state = S_IDLE;
        end
        else
        begin
          next_rec_cnt = rec_cnt + 8'h01;
        end
      S_IDLE:
        if (go)
        begin
          next_op      = fps_pkg::fps_op_t'(avs_writedata[2:0]);
          next_tries   = 4'h0;
          next_gave_up = 1'b0;
          next_state   = S_FIRST;
        end
      S_FIRST:
      begin
        next_cyc_start = 1'b1;
        next_cyc_read  = 1'b0;
        next_cyc_addr  = part_addr;
        unique case (op)
          fps_pkg::OP_CLEAR:
            next_cyc_wdata = fps_pkg::CMD_CLEAR;
          fps_pkg::OP_SET_LAYOUT:
          begin
            next_cyc_wdata = fps_pkg::CMD_CFG_SETUP;
            next_cyc_addr  = cfg_addr;
          end
          fps_pkg::OP_GET_LAYOUT:
            next_cyc_wdata = fps_pkg::CMD_READ_ID;
          fps_pkg::OP_PBUF:
            next_cyc_wdata = fps_pkg::CMD_PBUF_SETUP;
          default:
            next_cyc_wdata = fps_pkg::CMD_STATUS;
        endcase
        next_state = S_FWAIT;
      end
      S_FWAIT:
        if (cyc_done)
        begin
          if (op == fps_pkg::OP_CLEAR)
          begin
            next_errs  = 8'h00;
            next_state = S_IDLE;
          end
          else
          begin
            next_state = S_SECOND;
          end
        end
      S_SECOND:
      begin
        next_cyc_start = 1'b1;
        next_cyc_read  = op != fps_pkg::OP_SET_LAYOUT;
        next_cyc_wdata = fps_pkg::CMD_CFG_CONFIRM;
        if (op == fps_pkg::OP_SET_LAYOUT)
        begin
          next_cyc_addr = cfg_addr;
        end
        else if (op == fps_pkg::OP_GET_LAYOUT)
        begin
          next_cyc_addr = fps_pkg::LAYOUT_ID_ADDR;
        end
        else
        begin
          next_cyc_addr = part_addr;
        end
        next_state = S_SWAIT;
      end
      S_SWAIT:
        if (cyc_done)
        begin
          next_state = S_EVAL;
        end
      S_EVAL:
      begin
        next_state = S_IDLE;
        if (is_stat)
        begin
          // error bits only mean something once the engine is ready
          next_stat_byte = ready ? (cyc_rdata[7:0] & fps_pkg::STATUS_MASK) : 8'h00;
          if (ready)
          begin
            next_errs = errs | (cyc_rdata[7:0] & fps_pkg::ERROR_MASK);
          end
          if (op == fps_pkg::OP_POLL && !ready)
          begin
            next_state = S_SECOND;
          end
        end
        else if (op == fps_pkg::OP_PBUF)
        begin
          next_buf_avail = ready;
          if (!ready && tries != fps_pkg::PBUF_TRIES)
          begin
            next_tries = tries + 4'h1;
            next_state = S_FIRST;
          end
          else if (!ready)
          begin
            next_gave_up = 1'b1;
          end
        end
        else if (op == fps_pkg::OP_GET_LAYOUT)
        begin
          next_layout_rd = cyc_rdata[fps_pkg::LAYOUT_LSB +: 3];
        end
      end
      default:
        next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state       <= S_RECOV;
      op          <= fps_pkg::OP_NONE;
      rec_cnt     <= 8'h00;
      tries       <= 4'h0;
      cyc_start   <= 1'b0;
      cyc_read    <= 1'b0;
      cyc_addr    <= 22'h000000;
      cyc_wdata   <= 16'h0000;
      stat_byte   <= 8'h00;
      errs        <= 8'h00;
      buf_avail   <= 1'b0;
      gave_up     <= 1'b0;
      layout_rd   <= 3'h0;
      flash_rst_n <= 1'b0;
    end
    else if (clk_en)
    begin
      state       <= next_state;
      op          <= next_op;
      rec_cnt     <= next_rec_cnt;
      tries       <= next_tries;
      cyc_start   <= next_cyc_start;
      cyc_read    <= next_cyc_read;
      cyc_addr    <= next_cyc_addr;
      cyc_wdata   <= next_cyc_wdata;
      stat_byte   <= next_stat_byte;
      errs        <= next_errs;
      buf_avail   <= next_buf_avail;
      gave_up     <= next_gave_up;
      layout_rd   <= next_layout_rd;
      flash_rst_n <= next_flash_rst_n;
    end
  end

  fps_bus_cycle u_cycle
    (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .start    (cyc_start),
      .is_read  (cyc_read),
      .addr     (cyc_addr),
      .wdata    (cyc_wdata),
      .dq_in    (flash_dq_in),
      .pins     (flash_pins),
      .done     (cyc_done),
      .rdata    (cyc_rdata)
    );

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n || !clk_en);

  status_mask_a: assert property (
    (state == S_EVAL && is_stat && ready)
      |=> stat_byte == ($past(cyc_rdata[7:0]) & 8'hFE))
    else $error("status byte not masked");

  busy_invalid_a: assert property (
    (state == S_EVAL && is_stat && !ready) |=> stat_byte == 8'h00)
    else $error("status bits kept while busy");

  poll_again_a: assert property (
    (state == S_EVAL && op == fps_pkg::OP_POLL && !ready)
      |=> state == S_SECOND ##1 (cyc_start && cyc_read))
    else $error("poll did not reread");

  pbuf_retry_a: assert property (
    (state == S_EVAL && op == fps_pkg::OP_PBUF && !ready && tries != 4'h8)
      |=> state == S_FIRST ##1 (cyc_start && cyc_wdata == 16'h00E8))
    else $error("buffer setup not reissued");

  xstatus_mask_a: assert property (
    (state == S_EVAL && op == fps_pkg::OP_PBUF) |=> buf_avail == $past(cyc_rdata[7]))
    else $error("buffer flag wrong");

  layout_mask_a: assert property (
    (state == S_EVAL && op == fps_pkg::OP_GET_LAYOUT)
      |=> layout_rd == $past(cyc_rdata[10:8]))
    else $error("layout field wrong");

  layout_cycles_a: assert property (
    (cyc_start && op == fps_pkg::OP_SET_LAYOUT)
      |-> cyc_addr[15:0] == {5'h00, layout_req, 8'h00} && !cyc_read
          && cyc_wdata == (state == S_FWAIT ? 16'h0060 : 16'h0004))
    else $error("layout sequence wrong");

  status_addr_a: assert property (
    (cyc_start && is_stat) |-> cyc_addr == part_addr
      && (state == S_FWAIT ? cyc_wdata == 16'h0070 && !cyc_read : cyc_read))
    else $error("status cycle wrong");

  bus_answer_a: assert property (
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer late");

  poll_done_c: cover property (state == S_EVAL && op == fps_pkg::OP_POLL && ready);
  pbuf_retry_c: cover property (state == S_EVAL && op == fps_pkg::OP_PBUF && !ready);
  layout_set_c: cover property (state == S_EVAL && op == fps_pkg::OP_SET_LAYOUT);

endmodule : fps_host_ctrl

// File: core/fps_pkg.sv
// Purpose: shared constants and types for the flash partition host controller
// Assumes: core clock of 200 MHz; flash on an asynchronous 16-bit bus
// Notes:   least times round up to whole cycles
package fps_pkg;

  // ********************
  // timing
  // ********************
  localparam int CLK_NS       = 5;
  localparam int T_AVS_NS     = 10;
  localparam int T_WP_NS      = 50;
  localparam int T_GAP_NS     = 30;
  localparam int T_ACC_NS     = 80;
  localparam int T_RST_REC_NS = 150;
  localparam int SYNC_STAGES  = 2;

  function automatic logic [7:0] fps_ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1)
    begin
      c = 1;
    end
    fps_ns_to_cyc = c[7:0];
  endfunction : fps_ns_to_cyc

  localparam logic [7:0] SU_CYC  = fps_ns_to_cyc(T_AVS_NS);
  localparam logic [7:0] WP_CYC  = fps_ns_to_cyc(T_WP_NS);
  localparam logic [7:0] GAP_CYC = fps_ns_to_cyc(T_GAP_NS);
  // the read strobe is stretched by the synchroniser delay
  localparam logic [7:0] RD_CYC  = fps_ns_to_cyc(T_ACC_NS + SYNC_STAGES * CLK_NS);
  localparam logic [7:0] REC_CYC = fps_ns_to_cyc(T_RST_REC_NS);

  // ********************
  // flash commands and fields
  // ********************
  localparam logic [15:0] CMD_STATUS      = 16'h0070;
  localparam logic [15:0] CMD_CLEAR       = 16'h0050;
  localparam logic [15:0] CMD_CFG_SETUP   = 16'h0060;
  localparam logic [15:0] CMD_CFG_CONFIRM = 16'h0004;
  localparam logic [15:0] CMD_READ_ID     = 16'h0090;
  localparam logic [15:0] CMD_PBUF_SETUP  = 16'h00E8;
  localparam int          READY_BIT       = 7;
  localparam logic [7:0]  STATUS_MASK     = 8'hFE;
  localparam logic [7:0]  ERROR_MASK      = 8'h3A;
  localparam int          LAYOUT_LSB      = 8;
  localparam logic [2:0]  LAYOUT_BOT_DEF  = 3'h1;
  localparam logic [2:0]  LAYOUT_TOP_DEF  = 3'h4;
  localparam logic [21:0] LAYOUT_ID_ADDR  = 22'h000006;
  localparam logic [3:0]  PBUF_TRIES      = 4'h8;

  // ********************
  // register map
  // ********************
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_ADDR   = 5'h04;
  localparam logic [4:0] REG_LAYOUT = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0C;
  localparam logic [4:0] REG_ERRORS = 5'h10;
  localparam int         REJECT_BIT = 17;

  typedef enum logic [2:0] {
    OP_NONE       = 3'h0,
    OP_STATUS     = 3'h1,
    OP_POLL       = 3'h2,
    OP_CLEAR      = 3'h3,
    OP_SET_LAYOUT = 3'h4,
    OP_GET_LAYOUT = 3'h5,
    OP_PBUF       = 3'h6
  } fps_op_t;

  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [21:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
  } fps_pins_t;

  localparam fps_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 22'h000000, 16'h0000, 1'b0};

  // partitions formed by a layout code
  function automatic logic [2:0] fps_part_count(input logic [2:0] code);
    unique case (code)
      3'h0: fps_part_count = 3'h1;
      3'h1, 3'h2, 3'h4: fps_part_count = 3'h2;
      3'h3, 3'h5, 3'h6: fps_part_count = 3'h3;
      3'h7: fps_part_count = 3'h4;
    endcase
  endfunction : fps_part_count

endpackage : fps_pkg

// File: core/fps_bus_cycle.sv
// Purpose: one asynchronous flash bus cycle, write or read, timed in core clocks
// Assumes: start only taken while idle; done pulses once per cycle
// Notes:   data pins pass two flip-flops before capture
`timescale 1ns/1ps
module fps_bus_cycle
  (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              start,
    input  wire logic              is_read,
    input  wire logic [21:0]       addr,
    input  wire logic [15:0]       wdata,
    input  wire logic [15:0]       dq_in,
    output fps_pkg::fps_pins_t     pins,
    output logic                   done,
    output logic [15:0]            rdata
  );

  typedef enum logic [1:0] {
    E_IDLE  = 2'b00,
    E_SETUP = 2'b01,
    E_PULSE = 2'b11,
    E_GAP   = 2'b10
  } fps_eng_state_t;

  fps_eng_state_t     state;
  fps_eng_state_t     next_state;
  logic [7:0]         cnt;
  logic [7:0]         next_cnt;
  logic               rd;
  logic               next_rd;
  logic               next_done;
  logic [15:0]        next_rdata;
  fps_pkg::fps_pins_t next_pins;
  logic [15:0]        dq_s1;
  logic [15:0]        dq_s2;

  // ********************
  // cycle sequencer
  // ********************
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_rd    = rd;
    next_done  = 1'b0;
    next_rdata = rdata;
    next_pins  = pins;
    unique case (state)
      E_IDLE:
        if (start)
        begin
          // address settles before any strobe falls
          next_pins.addr   = addr;
          next_pins.dq_out = wdata;
          next_rd          = is_read;
          next_cnt         = fps_pkg::SU_CYC;
          next_state       = E_SETUP;
        end
      E_SETUP:
        if (cnt == 8'h01)
        begin
          next_pins.ce_n  = 1'b0;
          next_pins.oe_n  = !rd;
          next_pins.we_n  = rd;
          next_pins.dq_oe = !rd;
          next_cnt        = rd ? fps_pkg::RD_CYC : fps_pkg::WP_CYC;
          next_state      = E_PULSE;
        end
        else
        begin
          next_cnt = cnt - 8'h01;
        end
      E_PULSE:
        if (cnt == 8'h01)
        begin
          next_pins.ce_n  = 1'b1;
          next_pins.oe_n  = 1'b1;
          next_pins.we_n  = 1'b1;
          next_pins.dq_oe = 1'b0;
          if (rd)
          begin
            next_rdata = dq_s2;
          end
          next_cnt   = fps_pkg::GAP_CYC;
          next_state = E_GAP;
        end
        else
        begin
          next_cnt = cnt - 8'h01;
        end
      E_GAP:
        if (cnt == 8'h01)
        begin
          next_done  = 1'b1;
          next_state = E_IDLE;
        end
        else
        begin
          next_cnt = cnt - 8'h01;
        end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= E_IDLE;
      cnt   <= 8'h00;
      rd    <= 1'b0;
      done  <= 1'b0;
      rdata <= 16'h0000;
      pins  <= fps_pkg::PINS_IDLE;
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
    end
    else if (clk_en)
    begin
      state <= next_state;
      cnt   <= next_cnt;
      rd    <= next_rd;
      done  <= next_done;
      rdata <= next_rdata;
      pins  <= next_pins;
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

endmodule : fps_bus_cycle

// File: sim/fps_flash_model.sv
// Purpose: behavioural flash device behind the host controller
// Assumes: commands latched as a write pulse ends, ce_n and we_n may rise together
// Notes:   released bus shows the inverse of the last driven word
`timescale 1ns/1ps
module fps_flash_model
  #(
    parameter bit TOP_VARIANT = 1'b0
  )
  (
    input  wire logic          core_clk,
    input  fps_pkg::fps_pins_t flash_pins,
    input  wire logic          flash_rst_n,
    output logic [15:0]        flash_dq_in
  );
  // error flags move only with a clear; the busy count drops at the end of each status read
  logic [7:0]  sr_err = 8'h00;
  int          busy_left = 0;
  int          pb_refuse = 0;
  logic [2:0]  layout;
  logic [7:0]  mode;
  logic        cfg_pend;
  logic        we_q;
  logic        ce_q;
  logic        oe_q;
  logic [15:0] drv;
  logic [15:0] last = 16'h0000;
  // reserved bits read as ones so the host must mask them
  assign drv = mode == 8'h90 ? {5'h1F, layout, 8'hFF}
             : mode == 8'hE8 ? {8'hFF, pb_refuse == 0, 7'h7F}
             : busy_left > 0 ? 16'hFF7F
             : {8'hFF, 1'b1, sr_err[6:1], 1'b1};
  assign flash_dq_in = (!flash_pins.ce_n && !flash_pins.oe_n) ? drv : ~last;
  always @(posedge core_clk)
  begin
    we_q <= flash_pins.we_n;
    ce_q <= flash_pins.ce_n;
    oe_q <= flash_pins.oe_n;
    if (!flash_pins.oe_n)
      last <= drv;
    if (!flash_rst_n)
    begin
      layout   <= TOP_VARIANT ? 3'h4 : 3'h1;
      mode     <= 8'hFF;
      cfg_pend <= 1'b0;
    end
    // the host lifts both strobes at once, so chip enable is taken from the cycle before
    else if (!we_q && !ce_q && flash_pins.we_n)
    begin
      mode     <= flash_pins.dq_out[7:0];
      cfg_pend <= flash_pins.dq_out == 16'h0060;
      if (cfg_pend && flash_pins.dq_out == 16'h0004)
        layout <= flash_pins.addr[10:8];
      if (flash_pins.dq_out == 16'h0050)
        sr_err <= 8'h00;
    end
    else if (!oe_q && flash_pins.oe_n)
    begin
      if (mode == 8'h70 && busy_left > 0)
        busy_left <= busy_left - 1;
      if (mode == 8'hE8 && pb_refuse > 0)
        pb_refuse <= pb_refuse - 1;
    end
  end
endmodule : fps_flash_model

// File: sim/fps_host_ctrl_bench.sv
// Purpose: register level tests of the partition host controller
// Assumes: the controller answers each Avalon access in its own time
// Notes:   expected partition counts come from a table kept here
`timescale 1ns/1ps
module fps_host_ctrl_bench;
  logic               core_clk;
  logic               reset_n;
  logic [4:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  fps_pkg::fps_pins_t flash_pins;
  logic               flash_rst_n;
  logic [15:0]        flash_dq_in;
  logic [31:0]        q;
  int                 error_cnt = 0;
  int                 check_count = 0;
  localparam logic [2:0] PARTS [8] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h4};

  fps_host_ctrl fps_host_ctrl_i (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flash_pins(flash_pins), .flash_rst_n(flash_rst_n),
    .flash_dq_in(flash_dq_in));
  fps_flash_model fps_flash_model_i (.core_clk(core_clk), .flash_pins(flash_pins),
    .flash_rst_n(flash_rst_n), .flash_dq_in(flash_dq_in));

  // ********************
  // access tasks
  // ********************
  task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge core_clk);
  endtask : acc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // the poll ends when busy reads 0, with only the watchdog as limit; status lands in q afterwards
  task automatic run(input logic [2:0] op);
    acc(1'b1, fps_pkg::REG_CTRL, 32'(op));
    do acc(1'b0, fps_pkg::REG_CTRL, 32'h0); while (q[16] !== 1'b0);
    acc(1'b0, fps_pkg::REG_STATUS, 32'h0);
  endtask : run

  task automatic close_out;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    #200us;
    error_cnt++;
    close_out();
  end

  initial
  begin
    {reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    acc(1'b0, fps_pkg::REG_LAYOUT, 32'h0);
    chk(q & 32'h77, 32'h21);
    chk(32'(flash_rst_n), 32'h1);
    run(3'h1);
    chk(32'(q[17]), 32'h1);
    run(3'h5);
    chk(32'(q[14:9]), 32'h11);
    acc(1'b1, fps_pkg::REG_ADDR, 32'h003F0123);
    acc(1'b0, fps_pkg::REG_ADDR, 32'h0);
    chk(q, 32'h003F0123);
    fps_flash_model_i.sr_err = 8'h3A;
    run(3'h1);
    chk(q & 32'h800FF, 32'h800BA);
    fps_flash_model_i.sr_err = 8'h44;
    run(3'h1);
    chk(q & 32'hFF, 32'hC4);
    acc(1'b0, fps_pkg::REG_ERRORS, 32'h0);
    chk(q, 32'h3A);
    run(3'h3);
    acc(1'b0, fps_pkg::REG_ERRORS, 32'h0);
    chk(q, 32'h0);
    fps_flash_model_i.busy_left = 2;
    run(3'h1);
    chk(q & 32'hFF, 32'h0);
    run(3'h2);
    chk(q & 32'hFF, 32'h80);
    for (int c = 0; c < 8; c++)
    begin
      acc(1'b1, fps_pkg::REG_LAYOUT, 32'(c));
      run(3'h4);
      run(3'h5);
      chk(32'(q[14:9]), 32'({PARTS[c], c[2:0]}));
    end
    fps_flash_model_i.pb_refuse = 2;
    run(3'h6);
    chk(32'({q[18], q[8]}), 32'h1);
    fps_flash_model_i.pb_refuse = 20;
    run(3'h6);
    chk(32'({q[18], q[8]}), 32'h2);
    acc(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0);
    close_out();
  end
endmodule : fps_host_ctrl_bench
